// ==== design/rucs_array_ctrl.sv ====
`timescale 1ns/1ps
module rucs_array_ctrl #(
   parameter logic [rucs_pkg::SEC_W-1:0] CAP_SECTORS = 48'h0000_0010_0000,
   parameter logic CAP_IS_4K = 1'b0
) (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   // Status
   output logic [rucs_pkg::CHANNELS-1:0] SSD_ACTIVE_O,
   // Link
   rucs_link_if.ctl lk
);
   // ---------------------------------------------------------------
   // Request decode
   // ---------------------------------------------------------------
   logic busy_r, off_r, err_r, rd_valid_r;
   logic [2:0] cmd_r;
   logic [56:0] cnt_r, idx_r;
   logic [rucs_pkg::SEC_W-1:0] sec_r;
   logic [rucs_pkg::DW-1:0] rd_data_r;
   logic [rucs_pkg::DW-1:0] store [0:(1<<rucs_pkg::STORE_AW)-1];
   rucs_pkg::rucs_errf_t errf_r;
   // Out-of-range covers start plus length past the array end
   wire xfer_cmd = (lk.cmd == rucs_pkg::CMD_WRITE) | (lk.cmd == rucs_pkg::CMD_READ);
   wire [rucs_pkg::SEC_W:0] end_sec = {1'b0, lk.start_sector} + {1'b0, lk.sector_count};
   wire len_zero = xfer_cmd & (lk.sector_count == '0);
   wire range_bad = xfer_cmd & (end_sec > {1'b0, CAP_SECTORS});
   wire take = lk.req & ~busy_r & ~off_r;
   wire [56:0] words_xfer = {2'b00, lk.sector_count, 7'h00};
   wire [56:0] words_for = xfer_cmd ? words_xfer :
                           (lk.cmd == rucs_pkg::CMD_IDENTIFY) ? 57'(rucs_pkg::BUF_WORDS) :
                           (lk.cmd == rucs_pkg::CMD_SMART) ?
                           57'(rucs_pkg::CHANNELS * rucs_pkg::SMART_WORDS) : 57'd1;
   wire beat = busy_r & (cnt_r != '0);
   wire [56:0] abs_w = {2'b00, sec_r, 7'h00} + idx_r;
   wire [rucs_pkg::STORE_AW-1:0] st_a = abs_w[rucs_pkg::STORE_AW-1:0];
   wire smart_ch = idx_r[rucs_pkg::SECTOR_SHIFT];
   wire [rucs_pkg::BUF_AW-1:0] ctm_a = {smart_ch, 4'h0, idx_r[6:0]};

   // Command engine: latch on request, one beat per cycle until done
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         busy_r <= 1'b0;
         off_r <= 1'b0;
         err_r <= 1'b0;
         errf_r <= '0;
         cmd_r <= '0;
         cnt_r <= '0;
         idx_r <= '0;
         sec_r <= '0;
      end else if (take) begin
         busy_r <= 1'b1;
         cmd_r <= lk.cmd;
         sec_r <= lk.start_sector;
         idx_r <= '0;
         err_r <= len_zero | range_bad;
         for (int c = 0; c < rucs_pkg::CHANNELS; c++) begin
            errf_r[c] <= '0;
            errf_r[c][rucs_pkg::ERR_LEN_ZERO_BIT] <= len_zero;
            errf_r[c][rucs_pkg::ERR_RANGE_BIT] <= range_bad;
         end
         cnt_r <= (len_zero | range_bad) ? '0 : words_for;
      end else if (busy_r) begin
         if (cnt_r == '0) begin
            busy_r <= 1'b0;
            off_r <= (cmd_r == rucs_pkg::CMD_SHUTDOWN) & ~err_r;
         end else begin
            cnt_r <= cnt_r - 57'd1;
            idx_r <= idx_r + 57'd1;
         end
      end
   end

   // Small sector store so a Read returns what a Write left behind
   always_ff @(posedge SYS_CLK_I) begin
      if (beat & (cmd_r == rucs_pkg::CMD_WRITE)) begin
         store[st_a] <= lk.wr_data;
      end
   end

   // Read beat data, registered
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rd_valid_r <= 1'b0;
         rd_data_r <= '0;
      end else begin
         rd_valid_r <= beat & (cmd_r == rucs_pkg::CMD_READ);
         rd_data_r <= store[st_a];
      end
   end

   // Link outputs
   assign lk.busy = busy_r;
   assign lk.error = err_r & busy_r;
   assign lk.err_flags = errf_r;
   assign lk.cap_sectors = CAP_SECTORS;
   assign lk.cap_4k = CAP_IS_4K;
   assign lk.wr_ready = beat & (cmd_r == rucs_pkg::CMD_WRITE);
   assign lk.rd_valid = rd_valid_r;
   assign lk.rd_data = rd_data_r;
   assign lk.buf_we = beat & ((cmd_r == rucs_pkg::CMD_IDENTIFY) |
                              (cmd_r == rucs_pkg::CMD_SMART));
   assign lk.buf_sel = (cmd_r == rucs_pkg::CMD_SMART);
   assign lk.buf_addr = lk.buf_sel ? ctm_a : idx_r[rucs_pkg::BUF_AW-1:0];
   assign lk.buf_data = lk.buf_sel ? (lk.subm[smart_ch][0] ^ idx_r[31:0]) : idx_r[31:0];
   assign SSD_ACTIVE_O = off_r ? '0 : '1;
endmodule : rucs_array_ctrl

// ==== design/rucs_link_if.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Link between command sequencer and stripe array controller
// ------------------------------------------------------------------
interface rucs_link_if;
   logic req;
   logic [rucs_pkg::CMD_W-1:0] cmd;
   logic [rucs_pkg::SEC_W-1:0] start_sector;
   logic [rucs_pkg::SEC_W-1:0] sector_count;
   rucs_pkg::rucs_subm_t subm;
   logic busy;
   logic error;
   rucs_pkg::rucs_errf_t err_flags;
   logic [rucs_pkg::SEC_W-1:0] cap_sectors;
   logic cap_4k;
   logic wr_ready;
   logic [rucs_pkg::DW-1:0] wr_data;
   logic rd_valid;
   logic [rucs_pkg::DW-1:0] rd_data;
   logic buf_we;
   logic buf_sel;
   logic [rucs_pkg::BUF_AW-1:0] buf_addr;
   logic [rucs_pkg::DW-1:0] buf_data;

   modport dev (output req, cmd, start_sector, sector_count, subm, wr_data,
                input busy, error, err_flags, cap_sectors, cap_4k, wr_ready,
                rd_valid, rd_data, buf_we, buf_sel, buf_addr, buf_data);
   modport ctl (input req, cmd, start_sector, sector_count, subm, wr_data,
                output busy, error, err_flags, cap_sectors, cap_4k, wr_ready,
                rd_valid, rd_data, buf_we, buf_sel, buf_addr, buf_data);
endinterface : rucs_link_if

// ==== design/rucs_pkg.sv ====
package rucs_pkg;
   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam int CMD_W = 3;
   localparam logic [2:0] CMD_IDENTIFY = 3'h0;
   localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_READ = 3'h3;
   localparam logic [2:0] CMD_SMART = 3'h4;
   localparam logic [2:0] CMD_FLUSH = 3'h6;
   // ---------------------------------------------------------------
   // Status and capacity layout
   // ---------------------------------------------------------------
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_ERR_BIT = 1;
   localparam int STS_VERFAIL_BIT = 2;
   localparam int CAP_4K_BIT = 31;
   localparam int ERR_LEN_ZERO_BIT = 0;
   localparam int ERR_RANGE_BIT = 1;
   // ---------------------------------------------------------------
   // Widths and sizes
   // ---------------------------------------------------------------
   localparam int DW = 32;
   localparam int SEC_W = 48;
   localparam int CNT_W = 64;
   localparam int PAT_W = 3;
   localparam int CHANNELS = 2;
   localparam int SUBM_DWORDS = 16;
   localparam int SECTOR_BYTES = 512;
   localparam int WORD_BYTES = 4;
   localparam int WORDS_PER_SECTOR = SECTOR_BYTES / WORD_BYTES;
   localparam int SECTOR_SHIFT = 7;
   localparam int BUF_AW = 12;
   localparam int BUF_WORDS = 4096;
   localparam int CH_WORDS = 2048;
   localparam int SMART_WORDS = 128;
   localparam int STORE_AW = 8;
   localparam logic [DW-1:0] PAT_ONES = 32'hFFFF_FFFF;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ISSUE = 4'b0010,
      ST_RUN = 4'b0100,
      ST_OFF = 4'b1000
   } rucs_state_e;
   typedef logic [CHANNELS-1:0][SUBM_DWORDS-1:0][DW-1:0] rucs_subm_t;
   typedef logic [CHANNELS-1:0][DW-1:0] rucs_errf_t;

   // Test pattern per word index: 0 incr, 1 decr, 2 zeros, else ones
   function automatic logic [DW-1:0] rucs_pattern(input logic [PAT_W-1:0] sel,
                                                   input logic [DW-1:0] idx);
      unique case (sel)
         3'h0: rucs_pattern = idx;
         3'h1: rucs_pattern = ~idx;
         3'h2: rucs_pattern = '0;
         default: rucs_pattern = PAT_ONES;
      endcase
   endfunction : rucs_pattern
endpackage : rucs_pkg

// ==== design/rucs_sequencer.sv ====
`timescale 1ns/1ps
module rucs_sequencer (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   // User command and parameters
   input wire logic CMD_WR_I,
   input wire logic [rucs_pkg::CMD_W-1:0] CMD_CODE_I,
   input wire logic [rucs_pkg::SEC_W-1:0] START_SECTOR_I,
   input wire logic [rucs_pkg::SEC_W-1:0] TRANSFER_LENGTH_I,
   input wire logic [rucs_pkg::PAT_W-1:0] PATTERN_SELECT_I,
   // Custom submission entry write port
   input wire logic SUBM_WR_I,
   input wire logic SUBM_CH_I,
   input wire logic [3:0] SUBM_IDX_I,
   input wire logic [rucs_pkg::DW-1:0] SUBM_DATA_I,
   // Status
   output logic [rucs_pkg::DW-1:0] USER_STATUS_O,
   output logic [rucs_pkg::DW-1:0] CHANNEL_ERROR_FLAGS0_O,
   output logic [rucs_pkg::DW-1:0] CHANNEL_ERROR_FLAGS1_O,
   output logic [rucs_pkg::DW-1:0] ARRAY_CAPACITY_LO_O,
   output logic [rucs_pkg::DW-1:0] ARRAY_CAPACITY_HI_O,
   output logic [rucs_pkg::DW-1:0] BYTES_DONE_LO_O,
   output logic [rucs_pkg::DW-1:0] BYTES_DONE_HI_O,
   // Result buffer read ports
   input wire logic [rucs_pkg::BUF_AW-1:0] ID_RD_ADDR_I,
   output logic [rucs_pkg::DW-1:0] IDENTIFY_CONTROLLER_DATA_O,
   input wire logic [rucs_pkg::BUF_AW-1:0] CTM_RD_ADDR_I,
   output logic [rucs_pkg::DW-1:0] CUSTOM_RESULT_WINDOW_O,
   // Link to the stripe array controller
   rucs_link_if.dev lk
);
   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [rucs_pkg::DW-1:0] identify_buffer [0:rucs_pkg::BUF_WORDS-1];
   logic [rucs_pkg::DW-1:0] custom_result_buffer [0:rucs_pkg::BUF_WORDS-1];
   rucs_pkg::rucs_subm_t subm_r;
   rucs_pkg::rucs_state_e state_r, state_nxt;
   logic req_r, err_r, verfail_r;
   logic [rucs_pkg::CMD_W-1:0] cmd_r;
   logic [rucs_pkg::SEC_W-1:0] start_r, len_r;
   logic [rucs_pkg::PAT_W-1:0] pat_r;
   logic [rucs_pkg::DW-1:0] wr_idx_r, rd_idx_r, wr_data_r;
   logic [rucs_pkg::CNT_W-1:0] bytes_r;
   logic [rucs_pkg::DW-1:0] id_q_r, ctm_q_r, cap_lo_r, cap_hi_r;
   rucs_pkg::rucs_errf_t errf_r;

   // ---------------------------------------------------------------
   // Command acceptance
   // ---------------------------------------------------------------
   // Codes 101 and 111 have no command behind them and are dropped
   wire code_ok = (CMD_CODE_I != 3'h5) & (CMD_CODE_I != 3'h7);
   wire st_idle = (state_r == rucs_pkg::ST_IDLE);
   wire st_off = (state_r == rucs_pkg::ST_OFF);
   wire accept = CMD_WR_I & code_ok & st_idle;
   wire is_xfer = (cmd_r == rucs_pkg::CMD_WRITE) | (cmd_r == rucs_pkg::CMD_READ);
   wire [rucs_pkg::DW-1:0] exp_word = rucs_pkg::rucs_pattern(pat_r, rd_idx_r);
   wire mismatch = lk.rd_valid & (cmd_r == rucs_pkg::CMD_READ) & (lk.rd_data != exp_word);
   wire beat = lk.wr_ready | lk.rd_valid;

   // Sequencer: issue one request, wait for the controller to finish
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         rucs_pkg::ST_IDLE: if (accept) state_nxt = rucs_pkg::ST_ISSUE;
         rucs_pkg::ST_ISSUE: if (lk.busy) state_nxt = rucs_pkg::ST_RUN;
         rucs_pkg::ST_RUN: begin
            if (!lk.busy) begin
               // Shutdown leaves the array dead until RESET_N_I is asserted
               state_nxt = ((cmd_r == rucs_pkg::CMD_SHUTDOWN) & ~err_r) ?
                           rucs_pkg::ST_OFF : rucs_pkg::ST_IDLE;
            end
         end
         rucs_pkg::ST_OFF: state_nxt = rucs_pkg::ST_OFF;
         default: state_nxt = rucs_pkg::ST_IDLE;
      endcase
   end

   // State and command latch; parameters are taken with the code
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_r <= rucs_pkg::ST_IDLE;
         req_r <= 1'b0;
         cmd_r <= '0;
         start_r <= '0;
         len_r <= '0;
         pat_r <= '0;
      end else begin
         state_r <= state_nxt;
         req_r <= accept;
         if (accept) begin
            cmd_r <= CMD_CODE_I;
            start_r <= START_SECTOR_I;
            len_r <= TRANSFER_LENGTH_I;
            pat_r <= PATTERN_SELECT_I;
         end
      end
   end

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   // Set beats clear: an error in the accept cycle is kept
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         err_r <= 1'b0;
         verfail_r <= 1'b0;
         errf_r <= '0;
      end else begin
         err_r <= lk.error | (err_r & ~accept);
         verfail_r <= mismatch | (verfail_r & ~accept);
         if (lk.error) begin
            errf_r <= lk.err_flags;
         end else if (accept) begin
            errf_r <= '0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Data path: pattern out, check in, byte count
   // ---------------------------------------------------------------
   // Mismatch only flags; the transfer keeps running to the end
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         wr_idx_r <= '0;
         rd_idx_r <= '0;
         wr_data_r <= '0;
         bytes_r <= '0;
      end else if (accept) begin
         wr_idx_r <= '0;
         rd_idx_r <= '0;
         wr_data_r <= rucs_pkg::rucs_pattern(PATTERN_SELECT_I, '0);
         bytes_r <= '0;
      end else begin
         if (lk.wr_ready) begin
            wr_idx_r <= wr_idx_r + 32'd1;
            wr_data_r <= rucs_pkg::rucs_pattern(pat_r, wr_idx_r + 32'd1);
         end
         if (lk.rd_valid) begin
            rd_idx_r <= rd_idx_r + 32'd1;
         end
         if (beat & is_xfer) begin
            bytes_r <= bytes_r + 64'(rucs_pkg::WORD_BYTES);
         end
      end
   end

   // Submission entry, written by software before SMART or Flush
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         subm_r <= '0;
      end else if (SUBM_WR_I) begin
         subm_r[SUBM_CH_I][SUBM_IDX_I] <= SUBM_DATA_I;
      end
   end

   // Result buffers fill from the controller, read back registered
   always_ff @(posedge SYS_CLK_I) begin
      if (lk.buf_we & ~lk.buf_sel) begin
         identify_buffer[lk.buf_addr] <= lk.buf_data;
      end
      if (lk.buf_we & lk.buf_sel) begin
         custom_result_buffer[lk.buf_addr] <= lk.buf_data;
      end
      id_q_r <= identify_buffer[ID_RD_ADDR_I];
      ctm_q_r <= custom_result_buffer[CTM_RD_ADDR_I];
   end

   // Capacity pair; the 4K flag sits in bit 31 of the high word, commands still run
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         cap_lo_r <= '0;
         cap_hi_r <= '0;
      end else begin
         cap_lo_r <= lk.cap_sectors[31:0];
         cap_hi_r <= {16'h0000, lk.cap_sectors[rucs_pkg::SEC_W-1:32]};
         cap_hi_r[rucs_pkg::CAP_4K_BIT] <= lk.cap_4k;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      USER_STATUS_O = '0;
      USER_STATUS_O[rucs_pkg::STS_BUSY_BIT] = ~st_idle & ~st_off;
      USER_STATUS_O[rucs_pkg::STS_ERR_BIT] = err_r;
      USER_STATUS_O[rucs_pkg::STS_VERFAIL_BIT] = verfail_r;
   end
   assign CHANNEL_ERROR_FLAGS0_O = errf_r[0];
   assign CHANNEL_ERROR_FLAGS1_O = errf_r[1];
   assign ARRAY_CAPACITY_LO_O = cap_lo_r;
   assign ARRAY_CAPACITY_HI_O = cap_hi_r;
   assign BYTES_DONE_LO_O = bytes_r[31:0];
   assign BYTES_DONE_HI_O = bytes_r[63:32];
   assign IDENTIFY_CONTROLLER_DATA_O = id_q_r;
   assign CUSTOM_RESULT_WINDOW_O = ctm_q_r;
   assign lk.req = req_r;
   assign lk.cmd = cmd_r;
   assign lk.start_sector = start_r;
   assign lk.sector_count = len_r;
   assign lk.subm = subm_r;
   assign lk.wr_data = wr_data_r;
endmodule : rucs_sequencer

// ==== dv/rucs_checker_sva.sv ====
`timescale 1ns/1ps
module rucs_checker_sva (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   // Link signals
   input wire logic req,
   input wire logic [rucs_pkg::CMD_W-1:0] cmd,
   input wire logic [rucs_pkg::SEC_W-1:0] sector_count,
   input wire logic busy,
   input wire logic error,
   input wire logic wr_ready,
   input wire logic rd_valid,
   input wire logic buf_we,
   input wire logic buf_sel
);
   // ---------------------------------------------------------------
   // Write-beat counter per command, cleared by each request
   // ---------------------------------------------------------------
   logic [rucs_pkg::SEC_W+6:0] beats_r;
   logic bad_r;
   // Errors void the beat count, so they are remembered until the next request
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         beats_r <= '0;
         bad_r <= 1'b0;
      end else if (req) begin
         beats_r <= '0;
         bad_r <= 1'b0;
      end else begin
         beats_r <= beats_r + (rucs_pkg::SEC_W+7)'(wr_ready);
         bad_r <= bad_r | error;
      end
   end
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   a_req_one_pulse: assert property (req |=> !req)
      else $error("request longer than one cycle");
   a_req_then_busy: assert property (req |=> busy)
      else $error("controller not busy after request");
   a_no_req_busy: assert property (busy |-> !req)
      else $error("request issued while busy");
   a_req_code_legal: assert property (req |-> cmd inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6})
      else $error("request with reserved code");
   a_error_in_busy: assert property (error |-> busy)
      else $error("error outside a command");
   a_store_in_busy: assert property (buf_we |-> busy)
      else $error("buffer write outside a command");
   a_beats_in_busy: assert property (wr_ready || rd_valid |-> busy || $past(busy))
      else $error("data beat outside a command");
   a_params_held: assert property (busy |-> $stable(cmd) && $stable(sector_count))
      else $error("command parameters changed while busy");
   a_smart_custom: assert property (buf_we && cmd == 3'h4 |-> buf_sel)
      else $error("log data not sent to custom buffer");
   a_iden_buffer: assert property (buf_we && cmd == 3'h0 |-> !buf_sel)
      else $error("identify data not sent to identify buffer");
   a_write_beats: assert property ($fell(busy) && cmd == 3'h2 && !bad_r
      |-> beats_r == {sector_count, 7'h00})
      else $error("write beat count differs from sector count");
endmodule : rucs_checker_sva

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
   // ---------------------------------------------------------------
   // Stimulus, observation and instances
   // ---------------------------------------------------------------
   localparam logic [47:0] CAP = 48'h0001_0000_0400;
   logic SYS_CLK_I = 0, RESET_N_I = 0, CMD_WR_I = 0, SUBM_WR_I = 0, SUBM_CH_I = 0;
   logic [2:0] CMD_CODE_I = '0, PATTERN_SELECT_I = '0;
   logic [47:0] START_SECTOR_I = '0, TRANSFER_LENGTH_I = '0;
   logic [3:0] SUBM_IDX_I = '0;
   logic [31:0] SUBM_DATA_I = '0, sts, ef0, ef1, cap_lo, cap_hi, bd_lo, bd_hi, id_d, ctm_d;
   logic [31:0] id_word = '1, ctm_word = '1, rd_id, rd_ctm; // Preset so a missed snoop fails
   logic [11:0] ID_RD_ADDR_I = '0, CTM_RD_ADDR_I = '0;
   logic [1:0] ssd_on;
   logic seen;
   int n_mismatch = 0, n_checks = 0, n_beats = 0;
   rucs_link_if rucs_link_if_i ();
   rucs_sequencer rucs_sequencer_i (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
      .CMD_WR_I(CMD_WR_I), .CMD_CODE_I(CMD_CODE_I), .START_SECTOR_I(START_SECTOR_I),
      .TRANSFER_LENGTH_I(TRANSFER_LENGTH_I), .PATTERN_SELECT_I(PATTERN_SELECT_I),
      .SUBM_WR_I(SUBM_WR_I), .SUBM_CH_I(SUBM_CH_I), .SUBM_IDX_I(SUBM_IDX_I),
      .SUBM_DATA_I(SUBM_DATA_I), .USER_STATUS_O(sts), .CHANNEL_ERROR_FLAGS0_O(ef0),
      .CHANNEL_ERROR_FLAGS1_O(ef1), .ARRAY_CAPACITY_LO_O(cap_lo), .ARRAY_CAPACITY_HI_O(cap_hi),
      .BYTES_DONE_LO_O(bd_lo), .BYTES_DONE_HI_O(bd_hi), .ID_RD_ADDR_I(ID_RD_ADDR_I),
      .IDENTIFY_CONTROLLER_DATA_O(id_d), .CTM_RD_ADDR_I(CTM_RD_ADDR_I),
      .CUSTOM_RESULT_WINDOW_O(ctm_d), .lk(rucs_link_if_i.dev));
   rucs_array_ctrl #(.CAP_SECTORS(CAP), .CAP_IS_4K(1'b1)) rucs_array_ctrl_i (
      .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .SSD_ACTIVE_O(ssd_on),
      .lk(rucs_link_if_i.ctl));
   rucs_checker_sva rucs_checker_sva_i (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
      .req(rucs_link_if_i.req), .cmd(rucs_link_if_i.cmd),
      .sector_count(rucs_link_if_i.sector_count), .busy(rucs_link_if_i.busy),
      .error(rucs_link_if_i.error), .wr_ready(rucs_link_if_i.wr_ready),
      .rd_valid(rucs_link_if_i.rd_valid), .buf_we(rucs_link_if_i.buf_we),
      .buf_sel(rucs_link_if_i.buf_sel));
   // Clock
   initial begin
      forever #20 SYS_CLK_I = ~SYS_CLK_I;
   end
   // Wire snoop: one word of each stored result, and the write beats
   always @(posedge SYS_CLK_I) begin
      if (rucs_link_if_i.buf_we && rucs_link_if_i.buf_addr == 12'h005 && !rucs_link_if_i.buf_sel)
         id_word <= rucs_link_if_i.buf_data;
      if (rucs_link_if_i.buf_we && rucs_link_if_i.buf_addr == 12'h000 && rucs_link_if_i.buf_sel)
         ctm_word <= rucs_link_if_i.buf_data;
      if (rucs_link_if_i.wr_ready)
         n_beats++;
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   // One write of user_command; parameters stay put afterwards
   task automatic issue(input logic [2:0] c, input logic [47:0] s, input logic [47:0] n,
                        input logic [2:0] p);
      @(posedge SYS_CLK_I);
      #1;
      CMD_WR_I = 1'b1;
      CMD_CODE_I = c;
      START_SECTOR_I = s;
      TRANSFER_LENGTH_I = n;
      PATTERN_SELECT_I = p;
      @(posedge SYS_CLK_I);
      #1;
      CMD_WR_I = 1'b0;
   endtask : issue
   // Polls busy; notes whether a verify failure showed while still busy
   task automatic wait_idle();
      int i;
      seen = 1'b0;
      for (i = 0; i < 5000 && sts[0] !== 1'b0; i++) begin
         @(posedge SYS_CLK_I);
         #1;
         if (sts[2] === 1'b1 && sts[0] === 1'b1)
            seen = 1'b1;
      end
      if (i == 5000) begin
         n_mismatch++;
         $display("Error at %0t: command never finished", $time);
         conclude();
      end
   endtask : wait_idle
   task automatic rd_buf(input logic [11:0] a);
      @(posedge SYS_CLK_I);
      #1;
      ID_RD_ADDR_I = a;
      CTM_RD_ADDR_I = a;
      repeat (2) @(posedge SYS_CLK_I);
      #1;
      rd_id = id_d;
      rd_ctm = ctm_d;
   endtask : rd_buf
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_identify();
      issue(3'h0, '0, '0, '0);
      chk(sts[0], 1'b1, "identify busy");
      wait_idle();
      chk(sts, '0, "identify status");
      rd_buf(12'h005);
      chk(rd_id, id_word, "identify word");
      chk({cap_hi[15:0], cap_lo}, CAP, "capacity");
      chk(cap_hi[31], 1'b1, "4K flag");
   endtask : t_identify
   // Write, then a busy-time command and a reserved code, both ignored
   task automatic t_write_read();
      n_beats = 0;
      issue(3'h2, 48'h0, 48'h2, 3'h0);
      chk(sts[0], 1'b1, "write busy");
      issue(3'h6, 48'h0, 48'h2, 3'h0);
      wait_idle();
      repeat (3) @(posedge SYS_CLK_I);
      #1;
      chk(sts[0], 1'b0, "flush while busy ignored");
      chk(n_beats, 256, "write beats");
      chk({bd_hi, bd_lo}, 64'h0000_0000_0000_0400, "write bytes");
      issue(3'h5, 48'h0, 48'h2, 3'h0);
      chk(sts[0], 1'b0, "reserved code ignored");
      issue(3'h3, 48'h0, 48'h2, 3'h0);
      chk(sts[0], 1'b1, "read busy");
      repeat (20) @(posedge SYS_CLK_I);
      #1;
      chk(bd_lo > 32'h0 && bd_lo < 32'h400, 1'b1, "bytes mid run");
      wait_idle();
      chk(sts, '0, "matching read");
      issue(3'h3, 48'h0, 48'h2, 3'h2);
      wait_idle();
      chk(seen, 1'b1, "verify fail while running");
      chk(sts[2:0], 3'h4, "verify fail without error");
      chk({bd_hi, bd_lo}, 64'h0000_0000_0000_0400, "read ran to end");
   endtask : t_write_read
   task automatic t_errors();
      issue(3'h2, 48'h0, 48'h0, 3'h0);
      wait_idle();
      chk(sts[1], 1'b1, "zero length error");
      chk({ef1[0], ef0[0]}, 2'h3, "zero length flag");
      issue(3'h3, CAP, 48'h1, 3'h0);
      wait_idle();
      chk(sts[1], 1'b1, "range error");
      chk({ef1[1], ef0[1]}, 2'h3, "range flag");
   endtask : t_errors
   // Both channel entries loaded before the log request
   task automatic t_custom();
      for (int i = 0; i < 32; i++) begin
         @(posedge SYS_CLK_I);
         #1;
         SUBM_WR_I = 1'b1;
         SUBM_CH_I = i[4];
         SUBM_IDX_I = i[3:0];
         SUBM_DATA_I = 32'(i);
      end
      @(posedge SYS_CLK_I);
      #1;
      SUBM_WR_I = 1'b0;
      issue(3'h4, '0, '0, '0);
      chk(sts[0], 1'b1, "log busy");
      wait_idle();
      chk(sts, '0, "log done, error cleared");
      rd_buf(12'h000);
      chk(rd_ctm, ctm_word, "log word");
      issue(3'h6, '0, '0, '0);
      chk(sts[0], 1'b1, "flush busy");
      wait_idle();
      chk(sts, '0, "flush done");
   endtask : t_custom
   task automatic t_shutdown();
      chk(ssd_on, 2'h3, "drives active");
      issue(3'h1, '0, '0, '0);
      chk(sts[0], 1'b1, "shutdown busy");
      wait_idle();
      chk(ssd_on, 2'h0, "drives inactive");
      issue(3'h0, '0, '0, '0);
      chk(sts[0], 1'b0, "command after shutdown");
   endtask : t_shutdown
   // Main sequence
   initial begin
      repeat (8) @(posedge SYS_CLK_I);
      #1;
      RESET_N_I = 1'b1;
      chk(sts, '0, "reset status");
      t_identify();
      t_write_read();
      t_errors();
      t_custom();
      t_shutdown();
      conclude();
   end
endmodule : tb
